/* smrs_top.v */
// reset-source logic: supply monitors, reset pin, clock loss, comparator, cause flags
// Summary of operation
// [RULE1] supply below threshold drives reset pin low and holds core until recovered
// [RULE2] primary monitor on and selected after power-on, kept across other resets
// [RULE3] level monitor enabled as reset source after every reset
// [RULE4] flash write or erase without primary monitor on at high threshold resets
// [RULE5] firmware enables primary monitor and waits before selecting it
// [RULE6] supply reset releases without the extra power-on delay
// [RULE7] firmware writes the power-on bit as 1 on every cause register write
// [RULE8] firmware picks high threshold early when regulator is at default
// [RULE9] bit 7 switches primary monitor; resets only when also selected
// [RULE10] bit 6 reads live primary monitor output, 1 above threshold
// [RULE11] bit 5 picks low (0) or high (1) primary threshold
// [RULE12] bit 4 switches level monitor, which then is a reset source
// [RULE13] bits 3 to 0 reserved, writes ignored
// [RULE14] low reset pin resets device, pin flag set on exit
// [RULE15] clock stuck high or low over 100 us causes reset
// [RULE16] cause bit 2 flags clock-loss reset, write enables detector, pin undriven
// [RULE17] cause bit 5 write enables comparator reset, reads 1 after one
// [RULE18] firmware lets comparator settle before enabling it as reset source
// [RULE19] comparator reset leaves reset pin undriven
// [RULE20] power-on sets cause bit 1, other flags cleared
// [RULE21] writing cause bit 1 selects or deselects primary monitor as source
// [RULE22] core reset is OR of enabled sources, release on the clock
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "smrs_consts.vh"

module smrs_top #(
  parameter [11:0] CLK_LOSS_CYC = `SMRS_CLK_LOSS_CYC,
  parameter [3:0] HOLD_CYC = `SMRS_HOLD_CYC
) (
  // apb
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // analog monitors, modelled as levels
  input wire prim_above,
  input wire level_above,
  input wire cmp_below,
  // watched system clock
  input wire sys_clk_in,
  // flash controller, same clock
  input wire flash_prog_req,
  // reset pin, open drain
  input wire rst_pin_in,
  output reg rst_pin_out,
  output reg rst_pin_oe,
  // core reset
  output reg sys_rst_n,
  // primary monitor analog controls
  output reg monitor_on_out,
  output reg threshold_sel_out
);

  localparam ST_RUN = 1'b0;
  localparam ST_RESET = 1'b1;

  // synchronisers for pins and analog outputs
  reg prim_a;
  reg prim_s;
  reg level_a;
  reg level_s;
  reg cmp_a;
  reg cmp_s;
  reg pin_a;
  reg pin_s;

  // control state
  reg monitor_on;
  reg threshold_sel;
  reg level_on;
  reg prim_sel;
  reg clk_loss_en;
  reg cmp_en;

  // cause flags
  reg flag_poweron;
  reg flag_pin;
  reg flag_clk_loss;
  reg flag_cmp;
  reg flag_ferr;

  // causes gathered during a reset
  reg cause_sup;
  reg cause_pin;
  reg cause_clk;
  reg cause_cmp;
  reg cause_ferr;

  reg state;
  reg [3:0] hold;
  reg oe_d1;
  reg oe_d2;

  wire clk_timeout;
  wire prim_fault;
  wire level_fault;
  wire sup_fault;
  wire pin_fault;
  wire cmp_fault;
  wire ferr_fault;
  wire pulse_fault;
  wire level_src;
  wire any_fault;
  wire setup;
  wire wr_en;
  wire sel_sm;
  wire sel_rc;
  reg [7:0] next_rdata;

  smrs_clkmon #(
    .LIMIT_CYC(CLK_LOSS_CYC)
  ) u_clkmon (
    .pclk(pclk),
    .presetn(presetn),
    .enable(clk_loss_en),
    .watched_clk(sys_clk_in),
    .timeout(clk_timeout)
  );

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_a <= 1'b1;
      prim_s <= 1'b1;
      level_a <= 1'b1;
      level_s <= 1'b1;
      cmp_a <= 1'b0;
      cmp_s <= 1'b0;
      pin_a <= 1'b1;
      pin_s <= 1'b1;
    end else begin
      prim_a <= prim_above;
      prim_s <= prim_a;
      level_a <= level_above;
      level_s <= level_a;
      cmp_a <= cmp_below;
      cmp_s <= cmp_a;
      pin_a <= rst_pin_in;
      pin_s <= pin_a;
    end
  end

  // primary monitor needs both on and selected to reset
  assign prim_fault = monitor_on & prim_sel & ~prim_s; // [RULE9] [RULE21]
  assign level_fault = level_on & ~level_s; // [RULE12]
  assign sup_fault = prim_fault | level_fault;
  // our own drive must not read back as an external reset; the
  // read-back lags the drive by two sync stages, so mask those too
  assign pin_fault = ~pin_s & ~rst_pin_oe & ~oe_d1 & ~oe_d2; // [RULE14]
  assign cmp_fault = cmp_en & cmp_s; // [RULE17]
  // flash attempts while the core is held are meaningless, so gated
  assign ferr_fault = flash_prog_req & ~(monitor_on & threshold_sel) & sys_rst_n; // [RULE4]
  assign pulse_fault = clk_timeout | ferr_fault;
  assign level_src = sup_fault | pin_fault | cmp_fault;
  assign any_fault = level_src | pulse_fault; // [RULE22]

  // reset sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_RUN;
      hold <= 4'h0;
      sys_rst_n <= 1'b1;
      cause_sup <= 1'b0;
      cause_pin <= 1'b0;
      cause_clk <= 1'b0;
      cause_cmp <= 1'b0;
      cause_ferr <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (any_fault) begin
            state <= ST_RESET;
            sys_rst_n <= 1'b0; // [RULE22]
            hold <= pulse_fault ? HOLD_CYC : 4'h0;
            cause_sup <= sup_fault; // [RULE1]
            cause_pin <= pin_fault;
            cause_clk <= clk_timeout; // [RULE15]
            cause_cmp <= cmp_fault;
            cause_ferr <= ferr_fault;
          end
        end
        ST_RESET: begin
          cause_sup <= cause_sup | sup_fault;
          cause_pin <= cause_pin | pin_fault;
          cause_clk <= cause_clk | clk_timeout;
          cause_cmp <= cause_cmp | cmp_fault;
          if (clk_timeout) begin
            hold <= HOLD_CYC;
          end else if (hold != 4'h0) begin
            hold <= hold - 4'h1;
          end
          // supply release has no added delay beyond the clock
          if (!level_src && !clk_timeout && hold == 4'h0) begin // [RULE6]
            state <= ST_RUN;
            sys_rst_n <= 1'b1; // [RULE22]
          end
        end
        default: begin
          state <= ST_RUN;
          sys_rst_n <= 1'b1;
        end
      endcase
    end
  end

  // pin drive follows supply faults only
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_pin_out <= 1'b0;
      rst_pin_oe <= 1'b0;
      oe_d1 <= 1'b0;
      oe_d2 <= 1'b0;
    end else begin
      rst_pin_out <= 1'b0;
      oe_d1 <= rst_pin_oe;
      oe_d2 <= oe_d1;
      // clock-loss, comparator and flash resets leave the pin alone
      rst_pin_oe <= sup_fault; // [RULE1] [RULE16] [RULE19]
    end
  end

  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pready;
  assign sel_sm = (paddr == `SMRS_ADDR_SUPPLY_MON);
  assign sel_rc = (paddr == `SMRS_ADDR_RESET_CAUSE);

  // control bits and cause flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_on <= `SMRS_RST_MONITOR_ON; // [RULE2]
      threshold_sel <= `SMRS_RST_THRESHOLD_SEL;
      level_on <= `SMRS_RST_LEVEL_ON;
      prim_sel <= `SMRS_RST_PRIM_SEL; // [RULE2]
      clk_loss_en <= `SMRS_RST_CLK_LOSS_EN;
      cmp_en <= `SMRS_RST_CMP_EN;
      flag_poweron <= 1'b1; // [RULE20]
      flag_pin <= 1'b0;
      flag_clk_loss <= 1'b0;
      flag_cmp <= 1'b0;
      flag_ferr <= 1'b0;
    end else if (state == ST_RESET) begin
      // level monitor comes back on after any reset; primary keeps its state
      level_on <= 1'b1; // [RULE3]
      if (!level_src && !clk_timeout && hold == 4'h0) begin
        flag_poweron <= cause_sup; // [RULE20]
        flag_pin <= cause_pin; // [RULE14]
        flag_clk_loss <= cause_clk; // [RULE16]
        flag_cmp <= cause_cmp; // [RULE17]
        flag_ferr <= cause_ferr; // [RULE4]
      end
    end else if (wr_en && sel_sm) begin
      // reserved low bits are dropped
      monitor_on <= pwdata[`SMRS_SM_MONITOR_ON]; // [RULE9] [RULE13]
      threshold_sel <= pwdata[`SMRS_SM_THRESHOLD_SEL]; // [RULE11]
      level_on <= pwdata[`SMRS_SM_LEVEL_ON]; // [RULE12]
    end else if (wr_en && sel_rc) begin
      // firmware is expected to keep bit 1 set on every write
      prim_sel <= pwdata[`SMRS_RC_POWERON]; // [RULE21] [RULE7]
      clk_loss_en <= pwdata[`SMRS_RC_CLK_LOSS]; // [RULE16]
      cmp_en <= pwdata[`SMRS_RC_CMP]; // [RULE17]
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      monitor_on_out <= `SMRS_RST_MONITOR_ON;
      threshold_sel_out <= `SMRS_RST_THRESHOLD_SEL;
    end else begin
      monitor_on_out <= monitor_on; // [RULE9]
      threshold_sel_out <= threshold_sel; // [RULE11]
    end
  end

  // read mux
  always @* begin
    next_rdata = 8'h00;
    if (sel_sm) begin
      next_rdata[`SMRS_SM_MONITOR_ON] = monitor_on;
      next_rdata[`SMRS_SM_SUPPLY_ABOVE] = prim_s; // [RULE10]
      next_rdata[`SMRS_SM_THRESHOLD_SEL] = threshold_sel;
      next_rdata[`SMRS_SM_LEVEL_ON] = level_on; // [RULE13]
    end else if (sel_rc) begin
      next_rdata[`SMRS_RC_UNUSED] = 1'b1;
      next_rdata[`SMRS_RC_FLASH_ERR] = flag_ferr;
      next_rdata[`SMRS_RC_CMP] = flag_cmp; // [RULE17]
      next_rdata[`SMRS_RC_CLK_LOSS] = flag_clk_loss; // [RULE16]
      next_rdata[`SMRS_RC_POWERON] = flag_poweron; // [RULE20]
      next_rdata[`SMRS_RC_PIN] = flag_pin; // [RULE14]
    end
  end

  // one access cycle: answer prepared during setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~(sel_sm | sel_rc);
      if (setup && !pwrite) begin
        prdata <= {24'h00_0000, next_rdata};
      end else if (!psel) begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

/* smrs_consts.vh */
// register map, field positions, reset values and timing counts of the reset-source block
`ifndef SMRS_CONSTS_VH
`define SMRS_CONSTS_VH

// register indices; byte address is four times the index
`define SMRS_IDX_SUPPLY_MON 8'hFF
`define SMRS_IDX_RESET_CAUSE 8'hEF
`define SMRS_ADDR_SUPPLY_MON 12'h3FC
`define SMRS_ADDR_RESET_CAUSE 12'h3BC

// supply_monitor_control fields
`define SMRS_SM_MONITOR_ON 7
`define SMRS_SM_SUPPLY_ABOVE 6
`define SMRS_SM_THRESHOLD_SEL 5
`define SMRS_SM_LEVEL_ON 4

// reset_cause_register fields
`define SMRS_RC_UNUSED 7
`define SMRS_RC_FLASH_ERR 6
`define SMRS_RC_CMP 5
`define SMRS_RC_SOFT 4
`define SMRS_RC_WDT 3
`define SMRS_RC_CLK_LOSS 2
`define SMRS_RC_POWERON 1
`define SMRS_RC_PIN 0

// reset values after power-on
`define SMRS_RST_MONITOR_ON 1'b1
`define SMRS_RST_THRESHOLD_SEL 1'b0
`define SMRS_RST_LEVEL_ON 1'b1
`define SMRS_RST_PRIM_SEL 1'b1
`define SMRS_RST_CLK_LOSS_EN 1'b0
`define SMRS_RST_CMP_EN 1'b0

// timing
`define SMRS_PCLK_MHZ 25
`define SMRS_CLK_LOSS_TIME_US 100
// 100 us at 25 MHz, sized to the 12-bit detector counter
`define SMRS_CLK_LOSS_CYC 12'h9C4
`define SMRS_HOLD_CYC 4'h4

`endif

/* smrs_clkmon.v */
// missing-clock detector: times out when the watched clock stops toggling
`timescale 1ns/1ps
`include "smrs_consts.vh"

module smrs_clkmon #(
  parameter [11:0] LIMIT_CYC = `SMRS_CLK_LOSS_CYC
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire enable,
  input wire watched_clk,
  // result
  output reg timeout
);

  reg sync_a;
  reg sync_b;
  reg sync_c;
  reg [11:0] count;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
      sync_c <= 1'b0;
      count <= 12'h000;
      timeout <= 1'b0;
    end else begin
      sync_a <= watched_clk;
      sync_b <= sync_a;
      sync_c <= sync_b;
      timeout <= 1'b0;
      // any level change or a timeout restarts the count
      if (!enable || (sync_b != sync_c)) begin
        count <= 12'h000;
      end else if (count == LIMIT_CYC) begin
        // strictly more than the limit without an edge
        timeout <= 1'b1; // [RULE15]
        count <= 12'h000;
      end else begin
        count <= count + 12'h001;
      end
    end
  end

endmodule

/* smrs_top_assertions.sv */
// port-level checks of the reset-source block
`timescale 1ns/1ps
module smrs_top_chk #(
  parameter [11:0] CLK_LOSS_CYC = 12'h9C4,
  parameter [3:0] HOLD_CYC = 4'h4
) (
  // clock and reset
  input logic pclk,
  input logic presetn,
  // bus
  input logic pslverr,
  // monitors and flash
  input logic prim_above,
  input logic level_above,
  input logic flash_prog_req,
  // pin and core reset
  input logic rst_pin_in,
  input logic rst_pin_out,
  input logic rst_pin_oe,
  input logic sys_rst_n,
  input logic monitor_on_out,
  input logic threshold_sel_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles with both supplies good; sync delay needs a margin
  logic [2:0] ok_cnt;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) ok_cnt <= 3'h0;
    else if (!(prim_above && level_above)) ok_cnt <= 3'h0;
    else if (ok_cnt != 3'h7) ok_cnt <= ok_cnt + 3'h1;
  end
  a_oe_enters_reset: assert property ($rose(rst_pin_oe) |-> $fell(sys_rst_n))
    else $error("pin driven without reset entry");
  a_pin_drive_low: assert property (rst_pin_oe |-> !rst_pin_out && !sys_rst_n)
    else $error("pin drive wrong");
  a_level_fault: assert property (!level_above [*3] |=> !sys_rst_n && rst_pin_oe)
    else $error("level fault not reset");
  a_pin_undriven: assert property (ok_cnt >= 3'h5 |-> !rst_pin_oe)
    else $error("pin driven without supply fault");
  a_flash_refused: assert property (flash_prog_req && sys_rst_n
    && !(monitor_on_out && threshold_sel_out) |=> !sys_rst_n [*5])
    else $error("flash attempt not reset");
  a_reset_values: assert property ($rose(presetn) |-> monitor_on_out && !threshold_sel_out)
    else $error("monitor controls not at reset value");
  a_kept_in_reset: assert property (!sys_rst_n && !$past(sys_rst_n)
    |-> $stable(monitor_on_out) && $stable(threshold_sel_out))
    else $error("monitor controls changed in reset");
  a_pin_reset: assert property ((!rst_pin_in && !rst_pin_oe) [*3] |=> !sys_rst_n)
    else $error("pin low not reset");
  c_supply: cover property ($rose(rst_pin_oe));
  c_unmapped: cover property (pslverr);
  c_flash: cover property (flash_prog_req && !monitor_on_out);
endmodule
bind smrs_top smrs_top_chk #(.CLK_LOSS_CYC(CLK_LOSS_CYC), .HOLD_CYC(HOLD_CYC)) i_chk (
  .pclk(pclk), .presetn(presetn), .pslverr(pslverr), .prim_above(prim_above),
  .level_above(level_above), .flash_prog_req(flash_prog_req), .rst_pin_in(rst_pin_in),
  .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .sys_rst_n(sys_rst_n),
  .monitor_on_out(monitor_on_out), .threshold_sel_out(threshold_sel_out));

/* smrs_far.sv */
// reset pin wiring and watched clock outside the block
`timescale 1ns/1ps
module smrs_far (
  // clock
  input logic pclk,
  // bench control
  input logic ext_rst_n,
  input logic clk_run,
  // device side
  input logic rst_pin_out,
  input logic rst_pin_oe,
  output logic rst_pin_in,
  output logic sys_clk_in
);
  // open drain with pull-up; outside circuit may pull low too
  assign rst_pin_in = (rst_pin_oe ? rst_pin_out : 1'b1) & ext_rst_n;
  initial sys_clk_in = 1'b0;
  always @(posedge pclk) begin
    if (clk_run) sys_clk_in <= ~sys_clk_in;
  end
endmodule

/* tb_top.sv */
// self-checking bench of the reset-source block
`timescale 1ns/1ps
`include "smrs_consts.vh"
module tb_top;
  localparam [11:0] SM = `SMRS_ADDR_SUPPLY_MON;
  localparam [11:0] RC = `SMRS_ADDR_RESET_CAUSE;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic prim = 1'b1, lvl = 1'b1, cmp = 1'b0, flash = 1'b0, ext_n = 1'b1, clk_run = 1'b1;
  wire [31:0] prdata;
  wire pready, pslverr, pin_in, pin_out, pin_oe, sys_clk, sys_rst_n, mon_on, thr_sel;
  logic [32:0] exp_q[$];
  logic [31:0] r;
  int fail_count = 0;
  int comparisons = 0;
  always #20 pclk = ~pclk;
  smrs_top #(.CLK_LOSS_CYC(12'h014)) i_smrs_top (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .prim_above(prim),
    .level_above(lvl), .cmp_below(cmp), .sys_clk_in(sys_clk), .flash_prog_req(flash),
    .rst_pin_in(pin_in), .rst_pin_out(pin_out), .rst_pin_oe(pin_oe),
    .sys_rst_n(sys_rst_n), .monitor_on_out(mon_on), .threshold_sel_out(thr_sel));
  smrs_far i_smrs_far (.pclk(pclk), .ext_rst_n(ext_n), .clk_run(clk_run),
    .rst_pin_out(pin_out), .rst_pin_oe(pin_oe), .rst_pin_in(pin_in), .sys_clk_in(sys_clk));
  task end_sim;
    if (fail_count == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task check(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task chk1(input logic s, input logic e);
    check({32'h0000_0000, s}, {32'h0000_0000, e});
  endtask
  // read results leave the queue as the access cycle completes
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) check({pslverr, prdata}, exp_q.pop_front());
  end
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    n = 0;
    do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin fail_count++; end_sim(); end
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [11:0] a, input logic err, input logic [7:0] e);
    exp_q.push_back({err, 24'h00_0000, e});
    apb(1'b0, a, 32'h0000_0000);
  endtask
  task hold(input logic v, input int bound);
    int n;
    n = 0;
    while (sys_rst_n !== v && n < bound) begin @(posedge pclk); n++; end
    if (n >= bound) begin fail_count++; end_sim(); end
  endtask
  task pulse;
    flash <= 1'b1;
    @(posedge pclk) flash <= 1'b0;
  endtask
  initial begin
    void'($urandom(8932));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(SM, 1'b0, 8'hd0);
    rd(RC, 1'b0, 8'h82);
    rd(12'h004, 1'b1, 8'h00);
    r = $urandom;
    apb(1'b1, SM, {r[31:8], 4'h2, r[3:0]});
    prim <= 1'b0;
    repeat (8) @(posedge pclk);
    chk1(sys_rst_n, 1'b1);
    rd(SM, 1'b0, 8'h20);
    prim <= 1'b1;
    ext_n <= 1'b0; hold(1'b0, 10); ext_n <= 1'b1; hold(1'b1, 10);
    rd(SM, 1'b0, 8'h70);
    rd(RC, 1'b0, 8'h81);
    pulse(); hold(1'b0, 4); hold(1'b1, 12);
    rd(RC, 1'b0, 8'hc0);
    apb(1'b1, SM, 32'h0000_00b0);
    pulse(); repeat (8) @(posedge pclk);
    chk1(sys_rst_n, 1'b1);
    prim <= 1'b0; hold(1'b0, 6);
    chk1(pin_oe, 1'b1);
    chk1(pin_in, 1'b0);
    prim <= 1'b1; hold(1'b1, 5);
    rd(RC, 1'b0, 8'h82);
    apb(1'b1, RC, 32'h0000_0000);
    prim <= 1'b0; repeat (8) @(posedge pclk);
    chk1(sys_rst_n, 1'b1);
    prim <= 1'b1; repeat (4) @(posedge pclk);
    apb(1'b1, RC, 32'h0000_0002);
    lvl <= 1'b0; hold(1'b0, 6);
    chk1(pin_oe, 1'b1);
    lvl <= 1'b1; hold(1'b1, 5);
    rd(RC, 1'b0, 8'h82);
    apb(1'b1, RC, 32'h0000_0022);
    cmp <= 1'b1; hold(1'b0, 6);
    chk1(pin_oe, 1'b0);
    cmp <= 1'b0; hold(1'b1, 6);
    rd(RC, 1'b0, 8'ha0);
    apb(1'b1, RC, 32'h0000_0006);
    clk_run <= 1'b0; repeat (15) @(posedge pclk); clk_run <= 1'b1;
    repeat (4) @(posedge pclk);
    chk1(sys_rst_n, 1'b1);
    clk_run <= 1'b0; hold(1'b0, 40);
    chk1(pin_oe, 1'b0);
    clk_run <= 1'b1; hold(1'b1, 20);
    rd(RC, 1'b0, 8'h84);
    apb(1'b1, RC, 32'h0000_0002);
    clk_run <= 1'b0; repeat (40) @(posedge pclk);
    chk1(sys_rst_n, 1'b1);
    clk_run <= 1'b1;
    end_sim();
  end
  initial begin
    repeat (5000) @(posedge pclk);
    fail_count++;
    end_sim();
  end
endmodule
